/* File: design/rxawf_top.sv */
// Receive address filter and wake-up pattern detector with Avalon slave
// How it works
// - Perfect mode accepts only a destination equal to the station address, or broadcast while broadcast is not disabled.
// - Hash uses top six CRC bits of the destination to index 64 bits.
// - Index top bit picks high or low hash word, low five the bit.
// - Hash-only mode hash-checks every non-broadcast frame, multicast or physical.
// - Hash-perfect: physical exact match, multicast checked against hash.
// - Inverse mode accepts non-matching, rejects matching destinations.
// - Pass-all-multicast accepts every multicast frame in any mode.
// - Promiscuous accepts every frame, broadcast included.
// - Wake enable stops normal reception; only patterns are checked.
// - Wake frame sets the received flag and, at the same edge, interrupt or power event.
// - Clearing wake enable returns to normal reception.
// - In wake mode an enabled filter passing address and CRC wakes.
// - Mask bit j selects byte offset plus j; bit 31 is ignored.
// - Full power needs the enable; low-power state forces detection on.
// - Broadcast wake frames wake even with broadcast disabled.
// - Command bit 3 limits a filter to multicast, else unicast.
// - Command bit 0 enables a filter; bits 2:1 are reserved.
// - Table: four masks, commands, offsets, two CRC words; filter 0 low.
// - Offset counts bytes from the first destination byte.
// - Programmed CRC-16 equal to masked-byte CRC means a wake frame.
`timescale 1ns/100ps
module rxawf_top
  import rxawf_pkg::*;
(
  input  wire logic           i_clk,
  input  wire logic           i_reset_n,
  input  wire rxawf_avs_req_t i_avs,
  output logic [31:0]         o_avs_readdata,
  output logic                o_avs_waitrequest,
  input  wire rxawf_rx_byte_t i_rx,
  input  wire logic           i_power_d1,
  output logic                o_frame_accept,
  output logic                o_frame_reject,
  output logic                o_wake_irq,
  output logic                o_power_event_out
);

  rxawf_state_t s_q;
  rxawf_state_t s_d;

  logic [8:0]                pos;
  logic [47:0]               da_n;
  logic [31:0]               crc32_n;
  logic [47:0]               station;
  logic [63:0]               hash64;
  logic [5:0]                hash_idx;
  logic                      mcast;
  logic                      broadcast_disable;
  logic                      perfect;
  logic                      hash_hit;
  logic                      wake_active;
  logic                      eof_ev;
  logic                      long_enough;
  logic [NUM_FILT-1:0][15:0] crc16_n;
  logic [NUM_FILT-1:0]       filt_hit;
  logic                      wake_ev;
  logic                      acc_n;
  logic                      req;
  logic                      bus_do;

  // Reflected bit order: each byte enters the shift register LSB first
  function automatic logic [31:0] crc32_byte(input logic [31:0] c,
                                             input logic [7:0]  b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = {r[30:0], 1'b0} ^ ((r[31] ^ b[i]) ? CRC32_POLY : 32'h0);
    end
    return r;
  endfunction

  function automatic logic [15:0] crc16_byte(input logic [15:0] c,
                                             input logic [7:0]  b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i]) ? CRC16_POLY : 16'h0);
    end
    return r;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Byte position within the frame; sof restarts the count at zero
  assign pos     = i_rx.sof ? 9'h000 : s_q.cnt;
  assign eof_ev  = i_rx.valid & i_rx.eof;
  assign station = {s_q.addr_hi, s_q.addr_lo};
  assign hash64  = {s_q.hash_hi, s_q.hash_lo};

  always_comb begin
    da_n    = s_q.da;
    crc32_n = i_rx.sof ? CRC32_INIT : s_q.crc32;
    if (i_rx.valid && pos < DA_BYTES) begin
      da_n[8*pos[2:0] +: 8] = i_rx.data;
      crc32_n = crc32_byte(crc32_n, i_rx.data);
    end
  end

  assign hash_idx    = crc32_n[31:26];
  assign hash_hit    = hash64[hash_idx];
  assign mcast       = da_n[0];
  assign broadcast_disable       = &da_n;
  assign perfect     = (da_n == station);
  assign long_enough = (pos >= DA_BYTES - 9'h001);
  // Low-power state forces detection on; enable alone governs full power
  assign wake_active = s_q.wk_en | i_power_d1;

  // Per-filter masked CRC-16 and match
  for (genvar g = 0; g < NUM_FILT; g++) begin : g_filt
    logic [7:0]  ofs;
    logic [7:0]  cmd;
    logic [8:0]  rel;
    logic        sel;
    logic [15:0] base;
    logic [15:0] want;
    assign ofs  = s_q.tbl[TBL_OFS][8*g +: 8];
    assign cmd  = s_q.tbl[TBL_CMD][8*g +: 8];
    assign want = s_q.tbl[TBL_CRC + g/2][16*(g%2) +: 16];
    // Offset zero is the first destination byte
    assign rel  = pos - {1'b0, ofs};
    // Only mask bits 30:0 can ever be reached
    assign sel  = (pos >= {1'b0, ofs}) && (rel < MASK_LEN)
                  && s_q.tbl[g][rel[4:0]];
    assign base = i_rx.sof ? CRC16_INIT : s_q.crc16[g];
    assign crc16_n[g] = sel ? crc16_byte(base, i_rx.data)
                            : base;
    // Multicast type also covers broadcast, whatever broadcast_disable says
    assign filt_hit[g] = cmd[CMD_EN]
                         && (cmd[CMD_MCAST] ? mcast
                                            : (!mcast && perfect))
                         && (crc16_n[g] == want);
  end

  assign wake_ev = eof_ev & wake_active & long_enough
                   & (|filt_hit);

  // Normal address filter verdict, overrides first
  always_comb begin
    if (s_q.ctrl[BIT_PROMISCUOUS_ENABLE]) begin
      acc_n = 1'b1;
    end else if (mcast && s_q.ctrl[BIT_PAM]) begin
      acc_n = 1'b1;
    end else if (broadcast_disable) begin
      acc_n = !s_q.ctrl[BIT_BCD];
    end else if (s_q.ctrl[BIT_INV]) begin
      acc_n = !perfect;
    end else if (s_q.ctrl[BIT_HO]) begin
      acc_n = hash_hit;
    end else if (s_q.ctrl[BIT_HP]) begin
      acc_n = mcast ? hash_hit : perfect;
    end else begin
      acc_n = perfect;
    end
  end

  // Waitrequest drops for exactly one cycle per request; the access then
  // happens at that edge so read data is already stable when sampled
  assign req    = i_avs.read | i_avs.write;
  assign bus_do = req & ~s_q.wait_r;

  always_comb begin
    logic [31:0] w;
    logic        clr;
    w   = 32'h0;
    clr = 1'b0;
    s_d = s_q;
    s_d.accept = 1'b0;
    s_d.reject = 1'b0;

    s_d.wait_r = ~(req & s_q.wait_r);
    if (req && s_q.wait_r) begin
      unique case (i_avs.address)
        OFS_MAC_CTRL: s_d.rdata = {26'h0, s_q.ctrl};
        OFS_ADDR_LO:  s_d.rdata = s_q.addr_lo;
        OFS_ADDR_HI:  s_d.rdata = {16'h0, s_q.addr_hi};
        OFS_HASH_LO:  s_d.rdata = s_q.hash_lo;
        OFS_HASH_HI:  s_d.rdata = s_q.hash_hi;
        OFS_WAKE_CS:  s_d.rdata = {13'h0, s_q.ptr, 4'h0, s_q.hits, 3'h0,
                                   s_q.wfr, 1'b0, s_q.wk_pme, s_q.wk_irq,
                                   s_q.wk_en};
        OFS_WAKE_TBL: s_d.rdata = s_q.tbl[s_q.ptr];
        default:      s_d.rdata = 32'h0;
      endcase
    end

    if (bus_do) begin
      unique case (i_avs.address)
        OFS_MAC_CTRL: begin
          if (i_avs.write) begin
            w = be_merge({26'h0, s_q.ctrl}, i_avs.writedata,
                         i_avs.byteenable);
            s_d.ctrl = w[CTRL_W-1:0];
          end
        end
        OFS_ADDR_LO: begin
          if (i_avs.write) begin
            s_d.addr_lo = be_merge(s_q.addr_lo, i_avs.writedata,
                                   i_avs.byteenable);
          end
        end
        OFS_ADDR_HI: begin
          if (i_avs.write) begin
            w = be_merge({16'h0, s_q.addr_hi}, i_avs.writedata,
                         i_avs.byteenable);
            s_d.addr_hi = w[15:0];
          end
        end
        OFS_HASH_LO: begin
          if (i_avs.write) begin
            s_d.hash_lo = be_merge(s_q.hash_lo, i_avs.writedata,
                                   i_avs.byteenable);
          end
        end
        OFS_HASH_HI: begin
          if (i_avs.write) begin
            s_d.hash_hi = be_merge(s_q.hash_hi, i_avs.writedata,
                                   i_avs.byteenable);
          end
        end
        OFS_WAKE_CS: begin
          if (i_avs.write && i_avs.byteenable[0]) begin
            s_d.wk_en  = i_avs.writedata[WCS_EN];
            s_d.wk_irq = i_avs.writedata[WCS_IRQ];
            s_d.wk_pme = i_avs.writedata[WCS_PME];
            clr        = i_avs.writedata[WCS_RCVD];
          end
          if (i_avs.write && i_avs.byteenable[3]
              && i_avs.writedata[WCS_PTR_RST]) begin
            s_d.ptr = 3'h0;
          end
        end
        OFS_WAKE_TBL: begin
          // One port walks all eight words, so each access advances
          if (i_avs.write) begin
            s_d.tbl[s_q.ptr] = be_merge(s_q.tbl[s_q.ptr], i_avs.writedata,
                                        i_avs.byteenable);
          end
          s_d.ptr = s_q.ptr + 3'h1;
        end
        default: begin
        end
      endcase
    end

    if (i_rx.valid) begin
      s_d.cnt   = (pos == CNT_MAX) ? CNT_MAX : pos + 9'h001;
      s_d.da    = da_n;
      s_d.crc32 = crc32_n;
      s_d.crc16 = crc16_n;
    end

    if (eof_ev) begin
      if (wake_active) begin
        s_d.hits = long_enough ? filt_hit : '0;
      end else begin
        s_d.accept = long_enough & acc_n;
        s_d.reject = ~(long_enough & acc_n);
      end
    end

    // A wake event in the clearing cycle keeps the flag set
    s_d.wfr = wake_ev | (s_q.wfr & ~clr);
    s_d.irq = s_d.wfr & s_d.wk_irq;
    s_d.power_event_out = s_d.wfr & s_d.wk_pme;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q        <= '0;
      s_q.wait_r <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_avs_readdata    = s_q.rdata;
  assign o_avs_waitrequest = s_q.wait_r;
  assign o_frame_accept    = s_q.accept;
  assign o_frame_reject    = s_q.reject;
  assign o_wake_irq        = s_q.irq;
  assign o_power_event_out = s_q.power_event_out;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  a_promisc_accept: assert property (
    eof_ev && !wake_active && long_enough && s_q.ctrl[BIT_PROMISCUOUS_ENABLE]
    |=> o_frame_accept && !o_frame_reject)
    else $error("promiscuous frame not accepted");

  a_mcast_pass: assert property (
    eof_ev && !wake_active && long_enough && mcast && s_q.ctrl[BIT_PAM]
    |=> o_frame_accept)
    else $error("multicast frame not passed");

  a_perfect_match: assert property (
    eof_ev && !wake_active && long_enough && !broadcast_disable
    && s_q.ctrl == '0 |=> o_frame_accept == $past(perfect))
    else $error("perfect filter verdict wrong");

  a_inverse_reject: assert property (
    eof_ev && !wake_active && perfect && !mcast
    && s_q.ctrl == CTRL_W'(1 << BIT_INV) |=> o_frame_reject)
    else $error("inverse mode accepted own address");

  a_hash_only: assert property (
    eof_ev && !wake_active && long_enough && !broadcast_disable
    && s_q.ctrl[BIT_HO:BIT_PAM] == 4'h8
    |=> o_frame_accept == hash64[$past(hash_idx)])
    else $error("hash-only verdict wrong");

  a_wake_blocks: assert property (
    eof_ev && wake_active |=> !o_frame_accept && !o_frame_reject)
    else $error("normal verdict in wake mode");

  a_wake_flag: assert property (
    wake_ev |=> s_q.wfr && o_wake_irq == s_q.wk_irq
                && o_power_event_out == s_q.wk_pme)
    else $error("wake frame flag not raised");

  a_filter_off: assert property (
    eof_ev && wake_active
    |=> (s_q.hits & ~{s_q.tbl[TBL_CMD][24 + CMD_EN],
                      s_q.tbl[TBL_CMD][16 + CMD_EN],
                      s_q.tbl[TBL_CMD][8 + CMD_EN],
                      s_q.tbl[TBL_CMD][CMD_EN]}) == 4'h0)
    else $error("disabled filter reported a hit");

  a_low_power: assert property (
    eof_ev && i_power_d1 |=> !o_frame_accept ##1 !o_frame_accept
                              || $past(eof_ev))
    else $error("low-power state passed a frame");

endmodule // rxawf_top

/* File: design/rxawf_pkg.sv */
// Constants and types for the receive address and wake filter
package rxawf_pkg;

  // Register byte offsets on the Avalon slave
  localparam logic [4:0] OFS_MAC_CTRL = 5'h00;
  localparam logic [4:0] OFS_ADDR_LO  = 5'h04;
  localparam logic [4:0] OFS_ADDR_HI  = 5'h08;
  localparam logic [4:0] OFS_HASH_LO  = 5'h0C;
  localparam logic [4:0] OFS_HASH_HI  = 5'h10;
  localparam logic [4:0] OFS_WAKE_CS  = 5'h14;
  localparam logic [4:0] OFS_WAKE_TBL = 5'h18;

  // mac_control_reg fields
  localparam int CTRL_W    = 6;
  localparam int BIT_PAM   = 0;  // pass_all_multicast
  localparam int BIT_PROMISCUOUS_ENABLE  = 1;  // promiscuous_enable
  localparam int BIT_INV   = 2;  // inverse filtering
  localparam int BIT_HO    = 3;  // hash only
  localparam int BIT_HP    = 4;  // hash perfect
  localparam int BIT_BCD   = 5;  // broadcast_disable

  // wake_control_status fields
  localparam int WCS_EN      = 0;  // wake_frame_enable
  localparam int WCS_IRQ     = 1;  // route wake event to interrupt
  localparam int WCS_PME     = 2;  // route wake event to power_event_out
  localparam int WCS_RCVD    = 4;  // wake_frame_received, write one to clear
  localparam int WCS_HIT_LSB = 8;  // last per-filter hits, 4 bits
  localparam int WCS_PTR_LSB = 16; // table pointer, 3 bits
  localparam int WCS_PTR_RST = 31; // write one to rewind table pointer

  // Wake table layout
  localparam int NUM_FILT  = 4;
  localparam int TBL_WORDS = 8;
  localparam int TBL_CMD   = 4;
  localparam int TBL_OFS   = 5;
  localparam int TBL_CRC   = 6;
  localparam int CMD_EN    = 0;
  localparam int CMD_MCAST = 3;
  localparam logic [8:0] MASK_LEN = 9'h01F;

  // Frame and CRC constants
  localparam logic [8:0]  DA_BYTES   = 9'h006;
  localparam logic [8:0]  CNT_MAX    = 9'h1FF;
  localparam logic [31:0] CRC32_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC32_INIT = 32'hFFFFFFFF;
  localparam logic [15:0] CRC16_POLY = 16'h8005;
  localparam logic [15:0] CRC16_INIT = 16'hFFFF;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } rxawf_avs_req_t;

  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic [7:0] data;
  } rxawf_rx_byte_t;

  typedef struct packed {
    logic                      wait_r;
    logic [31:0]               rdata;
    logic [CTRL_W-1:0]         ctrl;
    logic [31:0]               addr_lo;
    logic [15:0]               addr_hi;
    logic [31:0]               hash_lo;
    logic [31:0]               hash_hi;
    logic                      wk_en;
    logic                      wk_irq;
    logic                      wk_pme;
    logic                      wfr;
    logic [NUM_FILT-1:0]       hits;
    logic [2:0]                ptr;
    logic [TBL_WORDS-1:0][31:0] tbl;
    logic [8:0]                cnt;
    logic [47:0]               da;
    logic [31:0]               crc32;
    logic [NUM_FILT-1:0][15:0] crc16;
    logic                      accept;
    logic                      reject;
    logic                      irq;
    logic                      power_event_out;
  } rxawf_state_t;

endpackage

/* File: sim/rxawf_phy_model.sv */
// Receive byte source standing in for the PHY side
`timescale 1ns/100ps
module rxawf_phy_model
  import rxawf_pkg::*;
(
  input  wire logic      i_clk,
  output rxawf_rx_byte_t o_rx
);
  logic [7:0] frame_q [$];

  initial o_rx = '0;

  // Idle data is the inverse of the last byte so stale data never matches
  task automatic send(input int gap);
    int n;
    n = frame_q.size();
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      o_rx <= '{1'b1, i == 0, i == n - 1, frame_q[i]};
      repeat (gap) begin
        @(posedge i_clk);
        o_rx <= '{1'b0, 1'b0, 1'b0, ~frame_q[i]};
      end
    end
    @(posedge i_clk);
    o_rx <= '{1'b0, 1'b0, 1'b0, ~frame_q[n - 1]};
    frame_q.delete();
  endtask
endmodule  // rxawf_phy_model

/* File: sim/rxawf_tb.sv */
// Self-checking bench for the receive address and wake filter
`timescale 1ns/100ps
module rx_address_and_wake_filter_tb_top
  import rxawf_pkg::*;
;
  localparam logic [47:0] ST = 48'h0A0908070602;
  localparam logic [47:0] UC = 48'h334455667788;
  localparam logic [47:0] MC = 48'h0100005E0001;
  localparam logic [47:0] BC = 48'hFFFFFFFFFFFF;
  logic           i_clk = 1'b0;
  logic           i_reset_n = 1'b0;
  rxawf_avs_req_t avs = '0;
  rxawf_rx_byte_t rx;
  logic           d1 = 1'b0;
  logic [31:0]    rdata;
  logic           waitreq;
  logic           acc;
  logic           rej;
  logic           irq;
  logic           power_event_out;
  logic [31:0]    rq;
  logic [7:0]     frm [20];
  int             err_count = 0;
  int             checked = 0;
  int             cycles = 0;
  int             acc_n = 0;
  int             rej_n = 0;

  always #20 i_clk = ~i_clk;

  rxawf_top dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_avs(avs),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_rx(rx),
    .i_power_d1(d1), .o_frame_accept(acc), .o_frame_reject(rej),
    .o_wake_irq(irq), .o_power_event_out(power_event_out));
  rxawf_phy_model phy (.i_clk(i_clk), .o_rx(rx));

  always @(posedge i_clk) begin
    if (acc === 1'b1) acc_n++;
    if (rej === 1'b1) rej_n++;
    if (i_reset_n && $isunknown({acc, rej, irq, power_event_out})) begin
      err_count++;
      $display("[FAIL] output levels expected known seen %b",
               {acc, rej, irq, power_event_out});
    end
    cycles++;
    // Whole run needs well under a thousand cycles
    if (cycles == 20000) begin
      err_count++;
      $display("[FAIL] cycle limit expected done seen %0d", cycles);
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_cnt(input string nm, input int e, input int g);
    checked++;
    if (g != e) begin
      err_count++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // Request held until waitrequest is sampled low at a rising edge
  task automatic av(input logic w, input logic [4:0] a,
                    input logic [31:0] d, input logic [3:0] be = 4'hF);
    int n;
    n = 0;
    @(posedge i_clk);
    avs <= '{~w, w, a, d, be};
    do begin
      @(posedge i_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    rq = rdata;
    avs <= '0;
    if (n >= 50) cmp("waitrequest", 32'h0, 32'h1);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    av(1'b1, a, d);
  endtask

  task automatic rd_chk(input string nm, input logic [4:0] a,
                        input logic [31:0] e);
    av(1'b0, a, 32'h0);
    cmp(nm, e, rq);
  endtask

  function automatic logic [31:0] crc_byte(input logic [31:0] c,
    input logic [31:0] poly, input int w, input logic [7:0] b);
    logic fb;
    for (int i = 0; i < 8; i++) begin
      fb = c[w-1] ^ b[i];
      c = c << 1;
      if (fb) c = c ^ poly;
    end
    return c;
  endfunction

  function automatic logic [5:0] hidx(input logic [47:0] da);
    logic [31:0] c;
    c = CRC32_INIT;
    for (int i = 0; i < 6; i++) c = crc_byte(c, CRC32_POLY, 32, da[8*i +: 8]);
    return c[31:26];
  endfunction

  // Masked pattern CRC over the shared frame; offset zero is the first destination byte
  function automatic logic [15:0] pcrc(input int ofs, input logic [30:0] m);
    logic [31:0] c;
    c = {16'h0, CRC16_INIT};
    for (int p = ofs; p < 20 && p < ofs + 31; p++)
      if (m[p-ofs]) c = crc_byte(c, {16'h0, CRC16_POLY}, 16, frm[p]);
    return c[15:0];
  endfunction

  task automatic build(input logic [47:0] da);
    for (int i = 0; i < 20; i++) begin
      frm[i] = (i < 6) ? da[8*i +: 8]
             : (i < 12) ? 8'(8'hA0 + i) : 8'(i * 3 + 1);
    end
  endtask

  task automatic frm_chk(input logic [47:0] da, input int ea, input int er,
                         input int gap = 0);
    int a0;
    int r0;
    a0 = acc_n;
    r0 = rej_n;
    build(da);
    for (int i = 0; i < 20; i++) phy.frame_q.push_back(frm[i]);
    phy.send(gap);
    repeat (3) @(posedge i_clk);
    cmp_cnt("accept pulses", ea, acc_n - a0);
    cmp_cnt("reject pulses", er, rej_n - r0);
  endtask

  task automatic set_hash(input logic [5:0] x);
    logic [63:0] h;
    h = 64'h1 << x;
    wr(OFS_HASH_LO, h[31:0]);
    wr(OFS_HASH_HI, h[63:32]);
  endtask

  task automatic t_reset();
    cmp("waitrequest", 32'h1, {31'h0, waitreq});
    cmp("outputs", 32'h0, {rdata[27:0], acc, rej, irq, power_event_out});
    rd_chk("wake status", OFS_WAKE_CS, 32'h0);
    // Only lanes 0 and 2 enabled; the other lanes keep their reset zero
    av(1'b1, OFS_HASH_LO, 32'h12345678, 4'h5);
    rd_chk("byte lanes", OFS_HASH_LO, 32'h00340078);
    $display("test reset done");
  endtask

  task automatic t_filters();
    wr(OFS_ADDR_LO, ST[31:0]);
    wr(OFS_ADDR_HI, {16'h0, ST[47:32]});
    wr(OFS_MAC_CTRL, 32'h0);
    frm_chk(ST, 1, 0);
    frm_chk(ST ^ 48'h100, 0, 1, 1);
    wr(OFS_MAC_CTRL, 32'h18);
    set_hash(hidx(UC));
    frm_chk(UC, 1, 0);
    set_hash(hidx(UC) ^ 6'h01);
    frm_chk(UC, 0, 1);
    set_hash(hidx(UC) ^ 6'h20);
    frm_chk(UC, 0, 1);
    wr(OFS_MAC_CTRL, 32'h10);
    set_hash(hidx(UC));
    frm_chk(UC, 0, 1);
    set_hash(hidx(MC));
    frm_chk(MC, 1, 0);
    frm_chk(ST, 1, 0);
    wr(OFS_MAC_CTRL, 32'h04);
    frm_chk(ST, 0, 1);
    frm_chk(UC, 1, 0);
    set_hash(hidx(MC) ^ 6'h01);
    wr(OFS_MAC_CTRL, 32'h01);
    frm_chk(MC, 1, 0);
    wr(OFS_MAC_CTRL, 32'h20);
    frm_chk(BC, 0, 1);
    wr(OFS_MAC_CTRL, 32'h22);
    frm_chk(BC, 1, 0);
    frm_chk(UC, 1, 0);
    $display("test filters done");
  endtask

  task automatic t_wake();
    logic [31:0] w [8];
    build(BC);
    // Filter 2 matches but is disabled with its reserved bits set
    w = '{32'h5, 32'h3, 32'h5, 32'h0, 32'h000E0109, 32'h140E0D0E,
          {pcrc(13, 31'h3), pcrc(14, 31'h5)}, {16'h0, pcrc(14, 31'h5)}};
    wr(OFS_WAKE_CS, 32'h80000000);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_WAKE_TBL, w[i]);
    end
    wr(OFS_WAKE_CS, 32'h80000000);
    rd_chk("table word 0", OFS_WAKE_TBL, 32'h5);
    wr(OFS_WAKE_CS, 32'h80000000);
    wr(OFS_MAC_CTRL, 32'h20);
    wr(OFS_WAKE_CS, 32'h3);
    frm_chk(BC, 0, 0);
    rd_chk("wake status", OFS_WAKE_CS, 32'h113);
    cmp("irq pme", 32'h2, {30'h0, irq, power_event_out});
    wr(OFS_WAKE_CS, 32'h15);
    frm_chk(ST, 0, 0, 1);
    rd_chk("wake status", OFS_WAKE_CS, 32'h215);
    cmp("irq pme", 32'h1, {30'h0, irq, power_event_out});
    wr(OFS_WAKE_CS, 32'h10);
    frm_chk(ST, 1, 0);
    cmp("irq pme", 32'h0, {30'h0, irq, power_event_out});
    @(posedge i_clk);
    d1 <= 1'b1;
    frm_chk(BC, 0, 0);
    rd_chk("wake status", OFS_WAKE_CS, 32'h110);
    d1 <= 1'b0;
    $display("test wake done");
  endtask

  task automatic t_unmapped();
    wr(5'h1C, 32'hA5A5A5A5);
    rd_chk("unmapped", 5'h1C, 32'h0);
    $display("test unmapped done");
  endtask

  initial begin
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    #1;
    t_reset();
    t_filters();
    t_wake();
    t_unmapped();
    stop_test();
  end
endmodule  // rx_address_and_wake_filter_tb_top
